// ### sfhc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sfhc_host_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic      [7:0] wdata_out,
  output logic            rd_out
);
  logic [7:0] shadow_12;
  logic       req_seen;

  initial
  begin
    addr_out  = 8'h00;
    wr_out    = 1'b0;
    wdata_out = 8'h00;
    rd_out    = 1'b0;
    shadow_12 = 8'h00;
    req_seen  = 1'b0;
  end

  // ----------
  // Bus cycles
  // ----------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge core_clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge core_clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(negedge core_clk_in);
    d = rdata_in;
  endtask

  // -------------
  // Host routines
  // -------------
  // Re-read until clear, at most four reads
  task automatic clear_latches(input logic [7:0] a);
    logic [7:0] v;
    v = 8'hFF;
    for (int n = 0; n < 4 && v !== 8'h00; n++)
      rd_reg(a, v);
  endtask

  task automatic poll_request();
    logic [7:0] a;
    logic [7:0] b;
    rd_reg(8'h02, a);
    rd_reg(8'h02, b);
    if (a[6] === b[6] && a[6] !== req_seen)
    begin
      req_seen     = a[6];
      shadow_12[1] = a[6];
      wr_reg(8'h12, shadow_12);
    end
  endtask
endmodule

`default_nettype wire

// ### sfhc_pkg.sv
package sfhc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LIVE_FAULTS_MON = 8'h00;
  localparam logic [7:0] ADDR_LIVE_HEALTH     = 8'h01;
  localparam logic [7:0] ADDR_LIVE_PINS       = 8'h02;
  localparam logic [7:0] ADDR_HOST_PWR_AC     = 8'h12;
  localparam logic [7:0] ADDR_HOST_CLAMP_ALRT = 8'h13;
  localparam logic [7:0] ADDR_ALERT_SEL_A     = 8'h1A;
  localparam logic [7:0] ADDR_ALERT_SEL_B     = 8'h1B;
  localparam logic [7:0] ADDR_LAT_FAULTS_MON  = 8'h2A;
  localparam logic [7:0] ADDR_LAT_HEALTH      = 8'h2B;
  localparam logic [7:0] ADDR_LAT_PINS        = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PWR_ON_BIT      = 1;
  localparam int unsigned AC_SENSE_BIT    = 5;
  localparam int unsigned CLAMP_REL_BIT   = 2;
  localparam int unsigned ALERT_DRIVE_BIT = 1;
  localparam int unsigned ALERT_CLR_BIT   = 0;
  localparam int unsigned REQ_PIN_BIT     = 6;
  localparam int unsigned AC_PIN_BIT      = 7;
  localparam int unsigned ORSW_OK_BIT     = 6;

  // ----------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] READ_EMPTY = 8'h00;
  localparam int unsigned SYNC_W    = 25;

endpackage

// ### sfhc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sfhc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Two flip-flop stages
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sfhc_sync_t;

  sfhc_sync_t st_reg;
  sfhc_sync_t st_next;

  always_comb
  begin
    st_next        = st_reg;
    st_next.stage1 = async_in;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stage2;

endmodule

`default_nettype wire

// ### sfhc_top.sv
// Behaviour
// - Reading a latched register clears its bits unless the fault is still present.
// - Power request pin state reads at bit 6 of the pin status register.
// - Host power-on bit 1 of 0x12 drives power-on; zero turns supply off.
// - In processor mode the request pin can be kept from the debounce block.
// - A fault selected in either alert-select mask raises the alert output.
// - Host AC-sense bit 5 of 0x12 drives line-good function; pin pass-through selectable.
// - Sensed AC state reads at bit 7 of the pin status register.
// - Bit 2 of 0x13 releases the share-bus clamp besides ramp release.
// - Bit 1 of 0x13 drives the alert output directly.
// - Writing bit 0 of 0x13 clears a latching alert output.
// - Register 0x00: monitors bits 0-4, overcurrent timeout, undervoltage, overvoltage.
// - Register 0x01: supply overvoltage, then seven active-low health flags.
// - Or-switch health low when pulse, enable, load or reverse good is false.
// - Supply health low on lockout, reference, ground or supply overvoltage fault.
// - Summary fault bit high on overvoltage, undervoltage or overcurrent.
// - Pin register bits 1-5: pulses, overcurrent, output-good, link, enable.
// - Three latched registers mirror the three live registers bit for bit.
// - Latched bits set only on a rising edge of their source.
// - Alert is the OR of flags selected by the two alert-select masks, the alert latch and bit 1 of 0x13.
`timescale 1ns/1ps
`default_nettype none

module sfhc_top (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  input  wire logic       cfg_cpu_mode_in,
  input  wire logic       cfg_request_pass_in,
  input  wire logic       cfg_ac_pass_in,
  input  wire logic       cfg_alert_latch_in,
  input  wire logic       monitor_input_one_in,
  input  wire logic       monitor_input_two_in,
  input  wire logic       monitor_input_three_in,
  input  wire logic       monitor_input_four_in,
  input  wire logic       monitor_input_five_in,
  input  wire logic       ov_fault_in,
  input  wire logic       uv_fault_in,
  input  wire logic       ocp_timeout_in,
  input  wire logic       supply_ov_in,
  input  wire logic       ext_ref_ok_in,
  input  wire logic       int_ref_ok_in,
  input  wire logic       ground_ok_in,
  input  wire logic       supply_lockout_level_in,
  input  wire logic       reverse_ok_in,
  input  wire logic       share_ok_in,
  input  wire logic       pulse_ok_in,
  input  wire logic       enable_ok_in,
  input  wire logic       load_ok_in,
  input  wire logic       ocp_sensed_in,
  input  wire logic       output_good_pin_in,
  input  wire logic       power_request_link_in,
  input  wire logic       power_enable_state_in,
  input  wire logic       power_request_pin_in,
  input  wire logic       ac_sense_in,
  input  wire logic       ramp_release_in,
  output logic      [7:0] reg_rdata_out,
  output logic            alert_output_out,
  output logic            power_on_cmd_out,
  output logic            line_good_out,
  output logic            share_bus_release_out,
  output logic            request_to_debounce_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [sfhc_pkg::SYNC_W-1:0] sync_q;
  logic monitor_input_one, mon2, mon3, mon4, monitor_input_five, ov_s, uv_s, ocpto_s, vddov_s;
  logic extref_s, intref_s, gnd_s, uvlo_s, rev_s, share_s, pulse_s;
  logic penok_s, loadok_s, ocpf_s, dcgood_s, link_s, pen_s, req_s, ac_s, ramp_s;

  sfhc_sync #(
    .W (sfhc_pkg::SYNC_W)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .async_in    ({monitor_input_one_in, monitor_input_two_in, monitor_input_three_in,
                   monitor_input_four_in, monitor_input_five_in, ov_fault_in, uv_fault_in,
                   ocp_timeout_in, supply_ov_in, ext_ref_ok_in, int_ref_ok_in, ground_ok_in,
                   supply_lockout_level_in, reverse_ok_in, share_ok_in, pulse_ok_in,
                   enable_ok_in, load_ok_in, ocp_sensed_in, output_good_pin_in,
                   power_request_link_in, power_enable_state_in, power_request_pin_in,
                   ac_sense_in, ramp_release_in}),
    .sync_out    (sync_q)
  );

  assign {monitor_input_one, mon2, mon3, mon4, monitor_input_five, ov_s, uv_s, ocpto_s, vddov_s, extref_s, intref_s,
          gnd_s, uvlo_s, rev_s, share_s, pulse_s, penok_s, loadok_s, ocpf_s, dcgood_s,
          link_s, pen_s, req_s, ac_s, ramp_s} = sync_q;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] live0;
    logic [7:0] live1;
    logic [7:0] live2;
    logic [7:0] lat0;
    logic [7:0] lat1;
    logic [7:0] lat2;
    logic [7:0] ctrl12;
    logic [7:0] ctrl13;
    logic [7:0] sel_a;
    logic [7:0] sel_b;
    logic [7:0] rdata;
    logic       alert_lat;
    logic       alert_pin;
    logic       pwr_on;
    logic       line_good;
    logic       clamp_rel;
    logic       req_deb;
  } sfhc_state_t;

  sfhc_state_t st_reg;
  sfhc_state_t st_next;

  // Rising-edge set, read clears bits whose source has gone
  function automatic logic [7:0] sfhc_latch_upd(input logic [7:0] lat,
                                                input logic [7:0] prev,
                                                input logic [7:0] now,
                                                input logic       rd);
    logic [7:0] rise;
    rise = now & ~prev;
    if (rd)
    begin
      sfhc_latch_upd = (lat & now) | rise;
    end
    else
    begin
      sfhc_latch_upd = lat | rise;
    end
  endfunction

  logic       orsw_ok;
  logic       vdd_ok;
  logic       fault_sum;
  logic [7:0] live0_n;
  logic [7:0] live1_n;
  logic [7:0] live2_n;
  logic       alert_raw;
  logic       wr12;
  logic       wr13;
  logic       alert_clr;

  always_comb
  begin
    orsw_ok   = pulse_s & penok_s & loadok_s & rev_s;
    vdd_ok    = ~uvlo_s & intref_s & extref_s & gnd_s & ~vddov_s;
    fault_sum = ov_s | uv_s | ocpf_s;
    live0_n   = {ov_s, uv_s, ocpto_s, monitor_input_one, mon2, mon3, mon4, monitor_input_five};
    live1_n   = {share_s, orsw_ok, rev_s, vdd_ok, gnd_s, intref_s, extref_s, vddov_s};
    live2_n   = {ac_s, req_s, pen_s, link_s, dcgood_s, ocpf_s, pulse_s, fault_sum};
    wr12      = reg_wr_in && (reg_addr_in == sfhc_pkg::ADDR_HOST_PWR_AC);
    wr13      = reg_wr_in && (reg_addr_in == sfhc_pkg::ADDR_HOST_CLAMP_ALRT);
    alert_clr = wr13 && reg_wdata_in[sfhc_pkg::ALERT_CLR_BIT];
    alert_raw = |(st_reg.sel_a & {ov_s, uv_s, ocpto_s, ~ac_s, ocpf_s, monitor_input_five, ~orsw_ok, ~share_s})
              | |(st_reg.sel_b & {~vdd_ok, monitor_input_one, mon2, mon3, mon4,
                                  st_reg.ctrl13[sfhc_pkg::ALERT_DRIVE_BIT], monitor_input_five, 1'b0});
  end

  always_comb
  begin
    st_next       = st_reg;
    st_next.live0 = live0_n;
    st_next.live1 = live1_n;
    st_next.live2 = live2_n;
    st_next.lat0  = sfhc_latch_upd(st_reg.lat0, st_reg.live0, live0_n,
                                   reg_rd_in && (reg_addr_in == sfhc_pkg::ADDR_LAT_FAULTS_MON));
    st_next.lat1  = sfhc_latch_upd(st_reg.lat1, st_reg.live1, live1_n,
                                   reg_rd_in && (reg_addr_in == sfhc_pkg::ADDR_LAT_HEALTH));
    st_next.lat2  = sfhc_latch_upd(st_reg.lat2, st_reg.live2, live2_n,
                                   reg_rd_in && (reg_addr_in == sfhc_pkg::ADDR_LAT_PINS));
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        sfhc_pkg::ADDR_HOST_PWR_AC:     st_next.ctrl12 = reg_wdata_in;
        sfhc_pkg::ADDR_HOST_CLAMP_ALRT: st_next.ctrl13 = reg_wdata_in;
        sfhc_pkg::ADDR_ALERT_SEL_A:     st_next.sel_a  = reg_wdata_in;
        sfhc_pkg::ADDR_ALERT_SEL_B:     st_next.sel_b  = reg_wdata_in;
        default:                        st_next.rdata  = st_reg.rdata;
      endcase
    end
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        sfhc_pkg::ADDR_LIVE_FAULTS_MON: st_next.rdata = st_reg.live0;
        sfhc_pkg::ADDR_LIVE_HEALTH:     st_next.rdata = st_reg.live1;
        sfhc_pkg::ADDR_LIVE_PINS:       st_next.rdata = st_reg.live2;
        sfhc_pkg::ADDR_HOST_PWR_AC:     st_next.rdata = st_reg.ctrl12;
        sfhc_pkg::ADDR_HOST_CLAMP_ALRT: st_next.rdata = st_reg.ctrl13;
        sfhc_pkg::ADDR_ALERT_SEL_A:     st_next.rdata = st_reg.sel_a;
        sfhc_pkg::ADDR_ALERT_SEL_B:     st_next.rdata = st_reg.sel_b;
        sfhc_pkg::ADDR_LAT_FAULTS_MON:  st_next.rdata = st_reg.lat0;
        sfhc_pkg::ADDR_LAT_HEALTH:      st_next.rdata = st_reg.lat1;
        sfhc_pkg::ADDR_LAT_PINS:        st_next.rdata = st_reg.lat2;
        default:                        st_next.rdata = sfhc_pkg::READ_EMPTY;
      endcase
    end
    // Alert latch, set wins over clear
    if (cfg_alert_latch_in)
    begin
      st_next.alert_lat = alert_raw | (st_reg.alert_lat & ~alert_clr);
    end
    else
    begin
      st_next.alert_lat = alert_raw;
    end
    st_next.alert_pin = st_next.alert_lat | st_next.ctrl13[sfhc_pkg::ALERT_DRIVE_BIT];
    st_next.pwr_on    = st_next.ctrl12[sfhc_pkg::PWR_ON_BIT];
    st_next.line_good = cfg_ac_pass_in ? ac_s : st_next.ctrl12[sfhc_pkg::AC_SENSE_BIT];
    st_next.clamp_rel = ramp_s | st_next.ctrl13[sfhc_pkg::CLAMP_REL_BIT];
    st_next.req_deb   = req_s & ~(cfg_cpu_mode_in & ~cfg_request_pass_in);
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_reg        <= '0;
      st_reg.ctrl12 <= sfhc_pkg::RST_BYTE;
      st_reg.ctrl13 <= sfhc_pkg::RST_BYTE;
      st_reg.sel_a  <= sfhc_pkg::RST_BYTE;
      st_reg.sel_b  <= sfhc_pkg::RST_BYTE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_out           = st_reg.rdata;
  assign alert_output_out        = st_reg.alert_pin;
  assign power_on_cmd_out        = st_reg.pwr_on;
  assign line_good_out           = st_reg.line_good;
  assign share_bus_release_out   = st_reg.clamp_rel;
  assign request_to_debounce_out = st_reg.req_deb;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_read_lat0;
    reg_rd_in && (reg_addr_in == sfhc_pkg::ADDR_LAT_FAULTS_MON);
  endsequence

  sequence s_write_ctrl12;
    reg_wr_in && (reg_addr_in == sfhc_pkg::ADDR_HOST_PWR_AC);
  endsequence

  a_read_clears_gone: assert property (s_read_lat0 and (live0_n == 8'h00) |=> st_reg.lat0 == 8'h00)
    else $error("latched bits survived read with no fault");
  a_read_keeps_fault: assert property (s_read_lat0 |=>
      (st_reg.lat0 & $past(st_reg.lat0) & st_reg.live0) == ($past(st_reg.lat0) & st_reg.live0))
    else $error("latched bit lost while fault present");
  a_req_pin_bit: assert property (##1 st_reg.live2[sfhc_pkg::REQ_PIN_BIT] == $past(req_s))
    else $error("request pin bit wrong");
  a_ac_pin_bit: assert property (##1 st_reg.live2[sfhc_pkg::AC_PIN_BIT] == $past(ac_s))
    else $error("ac pin bit wrong");
  a_power_cmd_follow: assert property (s_write_ctrl12 |=> power_on_cmd_out == $past(reg_wdata_in[sfhc_pkg::PWR_ON_BIT]) ##1 power_on_cmd_out == st_reg.ctrl12[sfhc_pkg::PWR_ON_BIT])
    else $error("power-on output does not follow host bit");
  a_debounce_blocked: assert property (cfg_cpu_mode_in && !cfg_request_pass_in |=> !request_to_debounce_out)
    else $error("request pin reached debounce while blocked");
  a_alert_on_fault: assert property (alert_raw |=> alert_output_out)
    else $error("alert not raised on selected flag");
  a_ac_host_drive: assert property (!cfg_ac_pass_in && !(reg_wr_in && (reg_addr_in == sfhc_pkg::ADDR_HOST_PWR_AC))
                                    |=> line_good_out == $past(st_reg.ctrl12[sfhc_pkg::AC_SENSE_BIT]))
    else $error("line good does not follow host bit");
  a_clamp_release: assert property (st_reg.ctrl13[sfhc_pkg::CLAMP_REL_BIT] |-> share_bus_release_out)
    else $error("clamp not released by host bit");
  a_alert_drive: assert property (st_reg.ctrl13[sfhc_pkg::ALERT_DRIVE_BIT] |-> alert_output_out)
    else $error("alert pin not driven by host bit");
  a_alert_clear: assert property (cfg_alert_latch_in && reg_wr_in && (reg_addr_in == sfhc_pkg::ADDR_HOST_CLAMP_ALRT)
                                  && reg_wdata_in[sfhc_pkg::ALERT_CLR_BIT] && !alert_raw |=> !st_reg.alert_lat)
    else $error("alert latch not cleared");
  a_orsw_health: assert property (##1 st_reg.live1[sfhc_pkg::ORSW_OK_BIT] == $past(pulse_s & penok_s & loadok_s & rev_s))
    else $error("or-switch health wrong");
  a_ro_write_ignored: assert property (reg_wr_in && !reg_rd_in && (reg_addr_in == sfhc_pkg::ADDR_LAT_FAULTS_MON)
                                       && (live0_n == 8'h00) |=> st_reg.lat0 == $past(st_reg.lat0))
    else $error("write changed latched register");

endmodule

`default_nettype wire

// ### sfhc_top_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic       core_clk_in;
  logic       nrst_in;
  logic [7:0] addr;
  logic       wr;
  logic [7:0] wdata;
  logic       rd;
  logic [7:0] rdata;
  logic [3:0] cfg;
  logic [7:0] flt;
  logic [7:0] hlt;
  logic [8:0] pin;
  logic       alert;
  logic       pwr_on;
  logic       line_good;
  logic       shr_rel;
  logic       req_dbn;
  int         error_cnt;
  int         checks_done;

  sfhc_host_model sfhc_host_model_i (.core_clk_in(core_clk_in), .rdata_in(rdata), .addr_out(addr),
    .wr_out(wr), .wdata_out(wdata), .rd_out(rd));

  sfhc_top sfhc_top_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .cfg_cpu_mode_in(cfg[3]), .cfg_request_pass_in(cfg[2]),
    .cfg_ac_pass_in(cfg[1]), .cfg_alert_latch_in(cfg[0]), .monitor_input_one_in(flt[4]),
    .monitor_input_two_in(flt[3]), .monitor_input_three_in(flt[2]), .monitor_input_four_in(flt[1]),
    .monitor_input_five_in(flt[0]), .ov_fault_in(flt[7]), .uv_fault_in(flt[6]), .ocp_timeout_in(flt[5]),
    .supply_ov_in(hlt[0]), .ext_ref_ok_in(hlt[1]), .int_ref_ok_in(hlt[2]), .ground_ok_in(hlt[3]),
    .supply_lockout_level_in(hlt[4]), .reverse_ok_in(hlt[5]), .load_ok_in(hlt[6]), .share_ok_in(hlt[7]),
    .pulse_ok_in(pin[0]), .enable_ok_in(pin[1]), .ocp_sensed_in(pin[2]), .output_good_pin_in(pin[3]),
    .power_request_link_in(pin[4]), .power_enable_state_in(pin[5]), .power_request_pin_in(pin[6]),
    .ac_sense_in(pin[7]), .ramp_release_in(pin[8]), .reg_rdata_out(rdata), .alert_output_out(alert),
    .power_on_cmd_out(pwr_on), .line_good_out(line_good), .share_bus_release_out(shr_rel),
    .request_to_debounce_out(req_dbn));

  initial
  begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  // -------
  // Helpers
  // -------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    sfhc_host_model_i.rd_reg(a, got);
    chk($sformatf("register %h", a), exp, got);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    sfhc_host_model_i.wr_reg(a, d);
    wait_clk(2);
  endtask

  // -----
  // Tests
  // -----
  task automatic t_reset();
    logic [7:0] regs [9] = '{8'h00, 8'h01, 8'h02, 8'h12, 8'h13, 8'h1A, 8'h1B, 8'h2A, 8'h55};
    for (int i = 0; i < 9; i++)
      chk_rd(regs[i], 8'h00);
    chk("power_on_cmd_out", 8'h00, {7'h00, pwr_on});
    $display("test reset done");
  endtask

  task automatic t_faults();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk_in) flt <= 8'h01 << i;
      wait_clk(5);
      chk_rd(8'h00, 8'h01 << i);
      @(posedge core_clk_in) flt <= 8'h00;
      wait_clk(5);
      chk_rd(8'h2A, 8'h01 << i);
      chk_rd(8'h2A, 8'h00);
    end
    sfhc_host_model_i.clear_latches(8'h2C);
    $display("test faults done");
  endtask

  task automatic t_persist();
    put(8'h2A, 8'hFF);
    chk_rd(8'h2A, 8'h00);
    @(posedge core_clk_in) flt <= 8'hFF;
    wait_clk(5);
    put(8'h2A, 8'h00);
    put(8'h00, 8'h00);
    chk_rd(8'h00, 8'hFF);
    chk_rd(8'h02, 8'h01);
    chk_rd(8'h2A, 8'hFF);
    chk_rd(8'h2A, 8'hFF);
    @(posedge core_clk_in) flt <= 8'h00;
    wait_clk(5);
    chk_rd(8'h2A, 8'hFF);
    chk_rd(8'h2A, 8'h00);
    sfhc_host_model_i.clear_latches(8'h2C);
    $display("test persist done");
  endtask

  task automatic t_health();
    logic [7:0] hin [6] = '{8'hAE, 8'hEE, 8'hFE, 8'hEF, 8'hE6, 8'hCE};
    logic [7:0] hex [6] = '{8'hBE, 8'hFE, 8'hEE, 8'hEF, 8'hE6, 8'h9E};
    @(posedge core_clk_in) pin <= 9'h003;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge core_clk_in) hlt <= hin[i];
      wait_clk(5);
      chk_rd(8'h01, hex[i]);
    end
    @(posedge core_clk_in) hlt <= 8'hEE;
    pin <= 9'h002;
    wait_clk(5);
    chk_rd(8'h01, 8'hBE);
    @(posedge core_clk_in) hlt <= 8'h00;
    pin <= 9'h000;
    wait_clk(5);
    sfhc_host_model_i.clear_latches(8'h2B);
    sfhc_host_model_i.clear_latches(8'h2C);
    $display("test health done");
  endtask

  task automatic t_pins();
    int         idx [7] = '{0, 2, 3, 4, 5, 6, 7};
    logic [7:0] exp [7] = '{8'h02, 8'h05, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    for (int i = 0; i < 7; i++)
    begin
      @(posedge core_clk_in) pin <= 9'h001 << idx[i];
      wait_clk(5);
      chk_rd(8'h02, exp[i]);
    end
    @(posedge core_clk_in) pin <= 9'h0FF;
    wait_clk(5);
    chk_rd(8'h02, 8'hFF);
    @(posedge core_clk_in) pin <= 9'h000;
    wait_clk(5);
    sfhc_host_model_i.clear_latches(8'h2C);
    $display("test pins done");
  endtask

  task automatic t_ctrl();
    put(8'h12, 8'h22);
    chk_rd(8'h12, 8'h22);
    chk("power_on_cmd_out", 8'h01, {7'h00, pwr_on});
    chk("line_good_out", 8'h01, {7'h00, line_good});
    put(8'h12, 8'h00);
    chk("power_on_cmd_out", 8'h00, {7'h00, pwr_on});
    @(posedge core_clk_in) cfg <= 4'h2;
    pin <= 9'h080;
    wait_clk(5);
    chk("line_good_out", 8'h01, {7'h00, line_good});
    @(posedge core_clk_in) pin <= 9'h100;
    wait_clk(5);
    chk("line_good_out", 8'h00, {7'h00, line_good});
    chk("share_bus_release_out", 8'h01, {7'h00, shr_rel});
    @(posedge core_clk_in) pin <= 9'h000;
    wait_clk(5);
    chk("share_bus_release_out", 8'h00, {7'h00, shr_rel});
    put(8'h13, 8'h04);
    chk("share_bus_release_out", 8'h01, {7'h00, shr_rel});
    chk_rd(8'h13, 8'h04);
    put(8'h13, 8'h00);
    @(posedge core_clk_in) cfg <= 4'h0;
    $display("test ctrl done");
  endtask

  task automatic t_alert();
    put(8'h1A, 8'h80);
    @(posedge core_clk_in) flt <= 8'h80;
    wait_clk(6);
    chk("alert_output_out", 8'h01, {7'h00, alert});
    @(posedge core_clk_in) flt <= 8'h00;
    wait_clk(6);
    chk("alert_output_out", 8'h00, {7'h00, alert});
    @(posedge core_clk_in) cfg <= 4'h1;
    flt <= 8'h80;
    wait_clk(6);
    @(posedge core_clk_in) flt <= 8'h00;
    wait_clk(6);
    chk("alert_output_out", 8'h01, {7'h00, alert});
    put(8'h13, 8'h01);
    chk("alert_output_out", 8'h00, {7'h00, alert});
    put(8'h13, 8'h00);
    put(8'h1A, 8'h00);
    @(posedge core_clk_in) flt <= 8'h80;
    wait_clk(6);
    chk("alert_output_out", 8'h00, {7'h00, alert});
    @(posedge core_clk_in) flt <= 8'h00;
    cfg <= 4'h0;
    put(8'h13, 8'h02);
    chk("alert_output_out", 8'h01, {7'h00, alert});
    put(8'h13, 8'h00);
    chk("alert_output_out", 8'h00, {7'h00, alert});
    put(8'h1B, 8'h40);
    @(posedge core_clk_in) flt <= 8'h10;
    wait_clk(6);
    chk("alert_output_out", 8'h01, {7'h00, alert});
    @(posedge core_clk_in) flt <= 8'h00;
    put(8'h1B, 8'h00);
    chk("alert_output_out", 8'h00, {7'h00, alert});
    sfhc_host_model_i.clear_latches(8'h2A);
    sfhc_host_model_i.clear_latches(8'h2C);
    $display("test alert done");
  endtask

  task automatic t_request();
    @(posedge core_clk_in) cfg <= 4'h8;
    pin <= 9'h040;
    wait_clk(5);
    chk("request_to_debounce_out", 8'h00, {7'h00, req_dbn});
    sfhc_host_model_i.poll_request();
    wait_clk(2);
    chk("power_on_cmd_out", 8'h01, {7'h00, pwr_on});
    @(posedge core_clk_in) cfg <= 4'hC;
    wait_clk(5);
    chk("request_to_debounce_out", 8'h01, {7'h00, req_dbn});
    @(posedge core_clk_in) pin <= 9'h000;
    wait_clk(5);
    sfhc_host_model_i.poll_request();
    wait_clk(2);
    chk("power_on_cmd_out", 8'h00, {7'h00, pwr_on});
    $display("test request done");
  endtask

  // -------
  // Verdict
  // -------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    error_cnt   = 0;
    checks_done = 0;
    nrst_in     = 1'b0;
    cfg         = 4'h0;
    flt         = 8'h00;
    hlt         = 8'h00;
    pin         = 9'h000;
    repeat (6) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_faults();
    t_persist();
    t_health();
    t_pins();
    t_ctrl();
    t_alert();
    t_request();
    complete_run();
  end
endmodule

`default_nettype wire
